// ==== verilog/cas_pkg.sv ====
// cas_pkg: register map, flag positions and reset values of the
// converter alarm status and mask block.
// assumes an 8-bit register port with 12-bit addresses.
package cas_pkg;

	localparam int          CAS_ADDR_W         = 12;
	localparam int          CAS_DATA_W         = 8;
	localparam int          CAS_FLAG_W         = 6;
	localparam int          CAS_LANES          = 8;
	localparam int          CAS_DIV_W          = 4;

	localparam logic [11:0] CAS_ADDR_SUMMARY   = 12'h2c0;
	localparam logic [11:0] CAS_ADDR_FLAGS     = 12'h2c1;
	localparam logic [11:0] CAS_ADDR_MASK      = 12'h2c2;
	localparam logic [11:0] CAS_ADDR_LANE_ERR  = 12'h2c4;

	localparam int          CAS_BIT_FIFO       = 5;
	localparam int          CAS_BIT_PLL        = 4;
	localparam int          CAS_BIT_LINK       = 3;
	localparam int          CAS_BIT_REALIGN    = 2;
	localparam int          CAS_BIT_RSVD       = 1;
	localparam int          CAS_BIT_CLK        = 0;

	localparam logic [5:0]  CAS_FLAGS_RST      = 6'h3f;
	localparam logic [7:0]  CAS_MASK_RST       = 8'h3f;
	localparam logic [7:0]  CAS_LANE_RST       = 8'hff;
	localparam logic [5:0]  CAS_ALARM_BITS     = 6'h3d;
	localparam logic [7:0]  CAS_RDATA_UNMAPPED = 8'h00;

	typedef enum logic [0:0] {
		CAS_ENC_8B10B  = 1'b0,
		CAS_ENC_64B66B = 1'b1
	} cas_enc_t;

endpackage

// ==== verilog/cas_sticky_if.sv ====
// cas_sticky_if: set, clear and value of a bank of sticky flags.
// assumes one producer of set, one owner of clr, one bank module.
interface cas_sticky_if #(
	parameter int W = 8
);
	logic [W-1:0] set;
	logic [W-1:0] clr;
	logic [W-1:0] q;

	modport src (output set);
	modport ctl (output clr, input q);
	modport own (input set, input clr, output q);
endinterface

// ==== verilog/cas_sticky_bank.sv ====
// cas_sticky_bank: bank of sticky flags, cleared by write-one pulses.
// assumes set and clr are single-cycle or level, synchronous to core_clk.
module cas_sticky_bank
	import cas_pkg::*;
#(
	parameter int         W   = 8,
	parameter logic [W-1:0] RST = '1
) (
	input  wire logic     core_clk,
	input  wire logic     srst,
	input  wire logic     soft_rst,
	cas_sticky_if.own     bank
);

	logic [W-1:0] flag_ff;

	assign bank.q = flag_ff;

	genvar gi;
	generate
		for (gi = 0; gi < W; gi++) begin : g_bit
			always_ff @(posedge core_clk) begin
				if (srst || soft_rst) begin
					flag_ff[gi] <= RST[gi];
				end else if (bank.set[gi]) begin
					// set wins over clr in the same cycle
					flag_ff[gi] <= 1'b1;
				end else if (bank.clr[gi]) begin
					flag_ff[gi] <= 1'b0;
				end
			end
		end
	endgenerate

endmodule

// ==== verilog/cas_cond_detect.sv ====
// cas_cond_detect: turns raw link and clock status into flag set terms.
// assumes all status inputs are synchronous to core_clk.
module cas_cond_detect
	import cas_pkg::*;
#(
	parameter int LANES = CAS_LANES,
	parameter int DIV_W = CAS_DIV_W
) (
	input  wire logic             core_clk,
	input  wire logic             srst,
	input  wire logic             soft_rst,
	input  wire logic             link_enable,
	input  wire cas_enc_t         link_enc,
	input  wire logic             link_in_data,
	input  wire logic             link_realign,
	input  wire logic             serializer_pll_locked,
	input  wire logic             clock_realigned,
	input  wire logic [DIV_W-1:0] div_phase_ab,
	input  wire logic [DIV_W-1:0] div_phase_cd,
	input  wire logic [LANES-1:0] lane_active,
	input  wire logic [LANES-1:0] lane_fifo_err,
	cas_sticky_if.src             flags,
	cas_sticky_if.src             lanes
);

	logic link_en_d_ff;
	logic link_start;
	logic link_term;

	always_ff @(posedge core_clk) begin
		if (srst || soft_rst) begin
			link_en_d_ff <= 1'b0;
		end else begin
			link_en_d_ff <= link_enable;
		end
	end

	assign link_start = link_enable & ~link_en_d_ff;

	always_comb begin
		if (link_enc == CAS_ENC_8B10B) begin
			// R03: enabled yet not in data
			link_term = link_enable & ~link_in_data;
		end else begin
			// R04: start or forced realign
			link_term = link_start | (link_enable & link_realign);
		end
	end

	// R15: per-lane record of fifo faults
	assign lanes.set = lane_fifo_err & lane_active;

	always_comb begin
		flags.set = '0;
		// R01: any active lane fifo fault
		flags.set[CAS_BIT_FIFO]    = |(lane_fifo_err & lane_active);
		// R02: serializer pll out of lock
		flags.set[CAS_BIT_PLL]     = ~serializer_pll_locked;
		flags.set[CAS_BIT_LINK]    = link_term;
		// R05: sysref clock realignment
		flags.set[CAS_BIT_REALIGN] = clock_realigned;
		// R06: divider pairs disagree
		// R09: no link enable gating
		flags.set[CAS_BIT_CLK]     = (div_phase_ab != div_phase_cd);
	end

endmodule

// ==== verilog/cas_alarm_top.sv ====
// cas_alarm_top: alarm status flags, mask, summary alarm and pin route.
// assumes a register port of address, write and read strobes from the
// serial front end, one access per cycle, all on core_clk.
// Function
// R01: fifo fault sets flag bit 5
// R02: pll unlock sets flag bit 4
// R03: 8b10b: enabled, not data, sets bit 3
// R04: 64b66b: start or realign sets bit 3
// R05: sysref realignment sets flag bit 2
// R06: divider mismatch sets flag bit 0
// R07: flags sticky, write one clears
// R08: reset loads flags 0x3f
// R09: only clock flag valid while disabled
// R10: software clears flags after enabling link
// R11: mask bits keep flags off summary
// R12: software writes mask reserved defaults
// R13: software reads per-lane register after fifo
// R14: summary is any unmasked flag set; code leaves reserved bit 1 out
// R15: clearing fifo flag clears per-lane bits
// R16: summary routable to cal status pin
// R17: set wins over same-cycle clear
module cas_alarm_top
	import cas_pkg::*;
#(
	parameter int LANES = CAS_LANES,
	parameter int DIV_W = CAS_DIV_W
) (
	input  wire logic                  core_clk,
	input  wire logic                  srst,
	input  wire logic                  soft_rst,
	input  wire logic [CAS_ADDR_W-1:0] reg_addr,
	input  wire logic                  reg_wr,
	input  wire logic [CAS_DATA_W-1:0] reg_wdata,
	input  wire logic                  reg_rd,
	output logic      [CAS_DATA_W-1:0] reg_rdata,
	input  wire logic                  link_enable,
	input  wire cas_enc_t              link_enc,
	input  wire logic                  link_in_data,
	input  wire logic                  link_realign,
	input  wire logic                  serializer_pll_locked,
	input  wire logic                  clock_realigned,
	input  wire logic [DIV_W-1:0]      div_phase_ab,
	input  wire logic [DIV_W-1:0]      div_phase_cd,
	input  wire logic [LANES-1:0]      lane_active,
	input  wire logic [LANES-1:0]      lane_fifo_err,
	input  wire logic                  cal_status_sel,
	input  wire logic                  cal_done,
	output logic                       summary_alarm,
	output logic                       cal_status_pin
);

	logic [CAS_DATA_W-1:0] alarm_flag_mask_ff;
	logic [CAS_DATA_W-1:0] rdata_ff;
	logic [CAS_DATA_W-1:0] nxt_rdata;
	logic                  summary_ff;
	logic                  cal_pin_ff;
	logic                  wr_flags;
	logic                  wr_mask;
	logic                  wr_lanes;
	logic [CAS_DATA_W-1:0] alarm_flags;
	logic [CAS_DATA_W-1:0] lane_bits;
	logic                  nxt_summary;

	cas_sticky_if #(.W(CAS_FLAG_W)) flag_bus ();
	cas_sticky_if #(.W(LANES))      lane_bus ();

	cas_cond_detect #(
		.LANES (LANES),
		.DIV_W (DIV_W)
	) u_detect (
		.core_clk              (core_clk),
		.srst                  (srst),
		.soft_rst              (soft_rst),
		.link_enable           (link_enable),
		.link_enc              (link_enc),
		.link_in_data          (link_in_data),
		.link_realign          (link_realign),
		.serializer_pll_locked (serializer_pll_locked),
		.clock_realigned       (clock_realigned),
		.div_phase_ab          (div_phase_ab),
		.div_phase_cd          (div_phase_cd),
		.lane_active           (lane_active),
		.lane_fifo_err         (lane_fifo_err),
		.flags                 (flag_bus.src),
		.lanes                 (lane_bus.src)
	);

	// R08: bank resets to all ones
	// R17: set beats clear inside bank
	cas_sticky_bank #(
		.W   (CAS_FLAG_W),
		.RST (CAS_FLAGS_RST)
	) u_flags (
		.core_clk (core_clk),
		.srst     (srst),
		.soft_rst (soft_rst),
		.bank     (flag_bus.own)
	);

	cas_sticky_bank #(
		.W   (LANES),
		.RST (LANES'(CAS_LANE_RST))
	) u_lanes (
		.core_clk (core_clk),
		.srst     (srst),
		.soft_rst (soft_rst),
		.bank     (lane_bus.own)
	);

	// address decode for writes
	always_comb begin
		wr_flags = 1'b0;
		wr_mask  = 1'b0;
		wr_lanes = 1'b0;
		if (reg_wr && reg_addr == CAS_ADDR_FLAGS) begin
			wr_flags = 1'b1;
		end else if (reg_wr && reg_addr == CAS_ADDR_MASK) begin
			wr_mask = 1'b1;
		end else if (reg_wr && reg_addr == CAS_ADDR_LANE_ERR) begin
			wr_lanes = 1'b1;
		end
	end

	// R07: write one clears the flag
	assign flag_bus.clr = wr_flags ? reg_wdata[CAS_FLAG_W-1:0]
		: '0;

	// R15: fifo flag clear empties lanes
	always_comb begin
		lane_bus.clr = '0;
		if (wr_lanes) begin
			lane_bus.clr = reg_wdata[LANES-1:0];
		end
		if (wr_flags && reg_wdata[CAS_BIT_FIFO]) begin
			lane_bus.clr = '1;
		end
	end

	// R11: mask register, plain read/write
	always_ff @(posedge core_clk) begin
		if (srst || soft_rst) begin
			alarm_flag_mask_ff <= CAS_MASK_RST;
		end else if (wr_mask) begin
			// reserved bits are stored as written; software keeps defaults
			alarm_flag_mask_ff <= reg_wdata;
		end
	end

	// reserved status bits 7:6 read as zero
	assign alarm_flags = {2'b00, flag_bus.q};
	assign lane_bits   = CAS_DATA_W'(lane_bus.q);

	// R14: any unmasked flag but reserved bit 1 raises summary
	// R11: masked flags are excluded
	assign nxt_summary = |(flag_bus.q & ~alarm_flag_mask_ff[5:0]
		& CAS_ALARM_BITS);

	always_ff @(posedge core_clk) begin
		if (srst || soft_rst) begin
			summary_ff <= 1'b0;
		end else begin
			summary_ff <= nxt_summary;
		end
	end

	// R16: pin shows summary when selected
	always_ff @(posedge core_clk) begin
		if (srst || soft_rst) begin
			cal_pin_ff <= 1'b0;
		end else if (cal_status_sel) begin
			cal_pin_ff <= nxt_summary;
		end else begin
			cal_pin_ff <= cal_done;
		end
	end

	// read decode; unmapped addresses answer zero
	always_comb begin
		nxt_rdata = CAS_RDATA_UNMAPPED;
		if (reg_addr == CAS_ADDR_SUMMARY) begin
			nxt_rdata = {7'h00, nxt_summary};
		end else if (reg_addr == CAS_ADDR_FLAGS) begin
			nxt_rdata = alarm_flags;
		end else if (reg_addr == CAS_ADDR_MASK) begin
			nxt_rdata = alarm_flag_mask_ff;
		end else if (reg_addr == CAS_ADDR_LANE_ERR) begin
			nxt_rdata = lane_bits;
		end
	end

	// read data holds until the next read strobe
	always_ff @(posedge core_clk) begin
		if (srst || soft_rst) begin
			rdata_ff <= CAS_RDATA_UNMAPPED;
		end else if (reg_rd) begin
			rdata_ff <= nxt_rdata;
		end
	end

	assign reg_rdata      = rdata_ff;
	assign summary_alarm  = summary_ff;
	assign cal_status_pin = cal_pin_ff;

endmodule

// ==== tb/cas_host_model.sv ====
// cas_host_model: host software doing register reads and writes.
// assumes the block takes strobes on the rising core_clk edge.
module cas_host_model (
	input  wire logic        core_clk,
	output logic      [11:0] reg_addr,
	output logic             reg_wr,
	output logic      [7:0]  reg_wdata,
	output logic             reg_rd,
	input  wire logic [7:0]  reg_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	initial {reg_addr, reg_wr, reg_wdata, reg_rd} = '0;
	// released address and data go inverted, strobes drop low, so a stale copy never passes
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [7:0] d, output logic [7:0] q);
		@(negedge core_clk);
		{reg_addr, reg_wdata, reg_wr, reg_rd} = {a, d, w, !w};
		@(negedge core_clk);
		{reg_addr, reg_wdata, reg_wr, reg_rd} = {~a, ~d, 2'b00};
		q = reg_rdata;
	endtask
endmodule

// ==== tb/cas_alarm_asserts.sv ====
// cas_alarm_asserts: port checks of the alarm block, flags seen by reads.
// assumes a bind into cas_alarm_top on its single clock.
module cas_alarm_asserts
	import cas_pkg::*;
#(parameter int LANES = 8, parameter int DIV_W = 4) (
	input wire logic             core_clk,
	input wire logic             srst,
	input wire logic             soft_rst,
	input wire logic [11:0]      reg_addr,
	input wire logic             reg_wr,
	input wire logic [7:0]       reg_wdata,
	input wire logic             reg_rd,
	input wire logic [7:0]       reg_rdata,
	input wire logic             link_enable,
	input wire cas_enc_t         link_enc,
	input wire logic             link_in_data,
	input wire logic             link_realign,
	input wire logic             serializer_pll_locked,
	input wire logic             clock_realigned,
	input wire logic [DIV_W-1:0] div_phase_ab,
	input wire logic [DIV_W-1:0] div_phase_cd,
	input wire logic [LANES-1:0] lane_active,
	input wire logic [LANES-1:0] lane_fifo_err,
	input wire logic             summary_alarm
);
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (srst || soft_rst);
	logic [7:0] mask_seen_ff;
	// mask as the host wrote it, so summary is judged from the rules
	always_ff @(posedge core_clk) begin
		if (srst || soft_rst) begin
			mask_seen_ff <= CAS_MASK_RST;
		end else if (reg_wr && reg_addr == CAS_ADDR_MASK) begin
			mask_seen_ff <= reg_wdata;
		end
	end
	sequence s_rd_flags;
		reg_rd && reg_addr == CAS_ADDR_FLAGS;
	endsequence
	property p_fifo;
		$past(|(lane_active & lane_fifo_err)) ##0 s_rd_flags |=> reg_rdata[5];
	endproperty
	a_fifo: assert property (p_fifo) else $error("fifo flag");
	property p_pll;
		$past(!serializer_pll_locked) ##0 s_rd_flags |=> reg_rdata[4];
	endproperty
	a_pll: assert property (p_pll) else $error("pll flag");
	property p_link8;
		$past(link_enable && !link_in_data && link_enc == CAS_ENC_8B10B)
			##0 s_rd_flags |=> reg_rdata[3];
	endproperty
	a_link8: assert property (p_link8) else $error("link flag");
	property p_link64;
		$past(link_enable && link_realign && link_enc == CAS_ENC_64B66B)
			##0 s_rd_flags |=> reg_rdata[3];
	endproperty
	a_link64: assert property (p_link64) else $error("realign");
	property p_realign;
		$past(clock_realigned) ##0 s_rd_flags |=> reg_rdata[2];
	endproperty
	a_realign: assert property (p_realign) else $error("sysref");
	property p_clk;
		$past(div_phase_ab != div_phase_cd) ##0 s_rd_flags |=> reg_rdata[0];
	endproperty
	a_clk: assert property (p_clk) else $error("clock flag");
	property p_reset;
		$past(srst) ##0 s_rd_flags |=> reg_rdata == 8'h3f;
	endproperty
	a_reset: assert property (p_reset) else $error("reset flags");
	// summary read and summary output come from the same term
	property p_sum;
		reg_rd && reg_addr == CAS_ADDR_SUMMARY |=>
			reg_rdata == {7'h00, summary_alarm};
	endproperty
	a_sum: assert property (p_sum) else $error("summary");
	// bit 1 never counts; flags read back must explain the summary output
	property p_sum_flags;
		s_rd_flags |=> summary_alarm ==
			|(reg_rdata[5:0] & ~$past(mask_seen_ff[5:0]) & 6'h3d);
	endproperty
	a_sum_flags: assert property (p_sum_flags) else $error("masking");
endmodule
bind cas_alarm_top cas_alarm_asserts #(.LANES(LANES), .DIV_W(DIV_W)) u_chk (
	.core_clk, .srst, .soft_rst, .reg_addr, .reg_wr, .reg_wdata,
	.reg_rd, .reg_rdata,
	.link_enable, .link_enc, .link_in_data, .link_realign,
	.serializer_pll_locked, .clock_realigned, .div_phase_ab, .div_phase_cd,
	.lane_active, .lane_fifo_err, .summary_alarm);

// ==== tb/cas_alarm_tb_top.sv ====
// cas_alarm_tb_top: scenario tasks around the alarm block.
// assumes cas_host_model as the only register master.
module cas_alarm_tb_top
	import cas_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0, srst = 1'b1, soft_rst = 1'b0, link_enable = 1'b1;
	logic link_in_data = 1'b1, link_realign = 1'b0, cal_done = 1'b0;
	logic serializer_pll_locked = 1'b1, clock_realigned = 1'b0;
	logic cal_status_sel = 1'b0, summary_alarm, cal_status_pin, reg_wr, reg_rd;
	logic [3:0] div_phase_ab = 4'h3, div_phase_cd = 4'h3;
	logic [7:0] lane_active = 8'hff, lane_fifo_err = 8'h00, reg_wdata;
	logic [7:0] reg_rdata, q;
	logic [11:0] reg_addr;
	cas_enc_t link_enc = CAS_ENC_8B10B;
	int bad_count = 0, total_checks = 0;
	always #2 core_clk = ~core_clk;
	cas_alarm_top i_dut (.core_clk, .srst, .soft_rst, .reg_addr, .reg_wr,
		.reg_wdata, .reg_rd, .reg_rdata, .link_enable, .link_enc,
		.link_in_data, .link_realign, .serializer_pll_locked,
		.clock_realigned, .div_phase_ab, .div_phase_cd, .lane_active,
		.lane_fifo_err, .cal_status_sel, .cal_done, .summary_alarm,
		.cal_status_pin);
	cas_host_model i_host (.core_clk, .reg_addr, .reg_wr, .reg_wdata,
		.reg_rd, .reg_rdata);
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		i_host.xfer(1'b1, a, d, q);
	endtask
	task automatic rc(input logic [11:0] a, input logic [7:0] exp);
		i_host.xfer(1'b0, a, 8'h00, q);
		chk(q, exp);
	endtask
	task automatic t_reset;
		rc(CAS_ADDR_FLAGS, 8'h3f);
		rc(CAS_ADDR_MASK, 8'h3f);
		wr(CAS_ADDR_FLAGS, 8'h3f);
		rc(CAS_ADDR_FLAGS, 8'h00);
		rc(CAS_ADDR_LANE_ERR, 8'h00);
	endtask
	// each fault but the one-cycle link start pulse of i == 6 is held until the read so the checker sees its cause
	task automatic t_conds;
		logic [55:0] exp = 56'h20100804010808;
		for (int i = 0; i < 7; i++) begin
			link_enable = (i != 6);
			@(negedge core_clk);
			link_enable = 1'b1;
			link_enc = (i >= 5) ? CAS_ENC_64B66B : CAS_ENC_8B10B;
			case (i)
				0: lane_fifo_err = 8'h04;
				1: serializer_pll_locked = 1'b0;
				2: link_in_data = 1'b0;
				3: clock_realigned = 1'b1;
				4: div_phase_cd = 4'h5;
				5: link_realign = 1'b1;
				default: ;
			endcase
			rc(CAS_ADDR_FLAGS, exp[8*(6-i) +: 8]);
			if (i == 0)
				rc(CAS_ADDR_LANE_ERR, 8'h04);
			{lane_fifo_err, serializer_pll_locked, link_in_data} = 10'h003;
			{clock_realigned, div_phase_cd, link_realign} = 6'h06;
			wr(CAS_ADDR_FLAGS, 8'h3f);
		end
		link_enc = CAS_ENC_8B10B;
	endtask
	task automatic t_setwins;
		serializer_pll_locked = 1'b0;
		wr(CAS_ADDR_FLAGS, 8'h10);
		serializer_pll_locked = 1'b1;
		rc(CAS_ADDR_FLAGS, 8'h10);
		wr(CAS_ADDR_FLAGS, 8'h00);
		rc(CAS_ADDR_FLAGS, 8'h10);
		wr(CAS_ADDR_FLAGS, 8'h10);
		rc(CAS_ADDR_FLAGS, 8'h00);
	endtask
	task automatic t_mask;
		wr(CAS_ADDR_MASK, 8'h2f);
		cal_status_sel = 1'b1;
		serializer_pll_locked = 1'b0;
		@(negedge core_clk);
		serializer_pll_locked = 1'b1;
		@(negedge core_clk);
		chk({6'h00, cal_status_pin, summary_alarm}, 8'h03);
		rc(CAS_ADDR_SUMMARY, 8'h01);
		rc(CAS_ADDR_FLAGS, 8'h10);
		wr(CAS_ADDR_MASK, 8'h3f);
		{cal_status_sel, cal_done} = 2'b01;
		@(negedge core_clk);
		chk({6'h00, cal_status_pin, summary_alarm}, 8'h02);
	endtask
	task automatic t_odd;
		wr(12'h2c3, 8'h00);
		rc(12'h2c3, 8'h00);
		rc(CAS_ADDR_MASK, 8'h3f);
		wr(CAS_ADDR_MASK, 8'h02);
		soft_rst = 1'b1;
		@(negedge core_clk);
		soft_rst = 1'b0;
		rc(CAS_ADDR_MASK, 8'h3f);
		rc(CAS_ADDR_FLAGS, 8'h3f);
		chk({7'h00, summary_alarm}, 8'h00);
	endtask
	task automatic conclude;
		$display("checks %0d errors %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		@(negedge core_clk);
		fork
			t_reset;
			begin
				@(negedge core_clk);
				srst = 1'b0;
			end
		join
		t_conds;
		t_setwins;
		t_mask;
		t_odd;
		conclude;
	end
endmodule
